// ==== rtl/dcl_lookup.v ====
// Purpose: walks root or extended root table then context table for one DMA request
// Assumes: memory answers one 64-bit word per mem_rd_valid, in request order
// Notes: one lookup at a time; req_ready is low while a walk is in progress
`timescale 1ns/1ps
`include "dcl_defines.vh"
module dcl_lookup (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        extended_context_supported,
  input  wire        root_table_type_select,
  input  wire [51:0] root_table_base_register,
  input  wire        req_valid,
  input  wire [15:0] req_source_id,
  input  wire        req_has_pasid,
  input  wire        req_is_page_request,
  output reg         req_ready,
  output reg         mem_rd_req,
  output reg  [63:0] mem_rd_addr,
  input  wire        mem_rd_valid,
  input  wire [63:0] mem_rd_data,
  output reg         rsp_valid,
  output reg         rsp_fault,
  output reg  [2:0]  rsp_fault_code,
  output reg         rsp_fault_report,
  output reg  [2:0]  rsp_trans_type,
  output reg  [2:0]  rsp_addr_width,
  output reg  [51:0] rsp_sl_pointer,
  output reg  [15:0] rsp_domain_id,
  output reg         rsp_fault_disable,
  output reg         rsp_first_level,
  output reg         rsp_second_level,
  output reg  [63:0] rsp_pasid_entry_addr,
  output reg         rsp_page_request_pass
);
  // One-hot walk states
  localparam ST_IDLE = 6'h01;
  localparam ST_ROOT = 6'h02;
  localparam ST_CTX0 = 6'h04;
  localparam ST_CTX1 = 6'h08;
  localparam ST_CTX2 = 6'h10;
  localparam ST_DONE = 6'h20;

  reg [5:0]  state;
  reg [15:0] sid;
  reg        has_pasid;
  reg        page_req;
  reg        ext_mode;
  reg [1:0]  word_cnt;
  reg [63:0] ctx_w0;
  reg [63:0] ctx_w1;

  wire [7:0]  devfn     = sid[7:0];
  wire        upper_dev = req_source_id[7]; // Incoming device 16-31 uses the upper half
  wire [63:0] root_addr;
  wire [63:0] ctx_addr;
  wire [63:0] xctx_addr;
  wire [63:0] pasid_addr;
  reg  [51:0] ctx_base;
  wire [7:0]  xctx_index = {1'b0, devfn[6:0]};

  // Root or extended root entry: 16 bytes each, 256 entries in 4KB
  dcl_fetch_addr #(.SHIFT(`DCL_ROOT_ENTRY_SHIFT)) u_root_addr (
    .base_page (root_table_base_register),
    .index     (req_source_id[15:8]),
    .addr      (root_addr)
  );
  // Regular context entry: 256 entries by full devfn
  dcl_fetch_addr #(.SHIFT(`DCL_CTX_ENTRY_SHIFT)) u_ctx_addr (
    .base_page (ctx_base),
    .index     (devfn),
    .addr      (ctx_addr)
  );
  // Extended context entry: 128 entries of 32 bytes by low 7 bits
  dcl_fetch_addr #(.SHIFT(`DCL_XCTX_ENTRY_SHIFT)) u_xctx_addr (
    .base_page (ctx_base),
    .index     (xctx_index),
    .addr      (xctx_addr)
  );
  // Per-process table base, 8-byte entries indexed outside this block
  dcl_fetch_addr #(.SHIFT(`DCL_PASID_ENTRY_SHIFT)) u_pasid_addr (
    .base_page (ctx_w1[`DCL_PTR_MSB:`DCL_PTR_LSB]),
    .index     (8'h00),
    .addr      (pasid_addr)
  );

  // Translation type check and level selection
  reg [2:0] tt;
  reg       type_ok;
  reg       fl;
  reg       sl;
  always @* begin
    tt      = ctx_w0[`DCL_TT_MSB:`DCL_TT_LSB];
    type_ok = 1'b0;
    fl      = 1'b0;
    sl      = 1'b0;
    if (!ext_mode) begin
      type_ok = !has_pasid && (tt == `DCL_TT_UNTRANS || tt == `DCL_TT_SL_ONLY
                || tt == `DCL_TT_PASSTHRU);
      sl      = (tt != `DCL_TT_PASSTHRU);
    end else if (has_pasid) begin
      type_ok = (tt == `DCL_TT_FL_ONLY || tt == `DCL_TT_NESTED);
      fl      = 1'b1;
      sl      = (tt == `DCL_TT_NESTED);
    end else begin
      type_ok = (tt != `DCL_TT_FL_ONLY);
      sl      = (tt != `DCL_TT_PASSTHRU);
    end
  end

  // Present bit and pointer of the fetched root half or regular root entry
  wire        half_present = mem_rd_data[`DCL_PRESENT_BIT];
  wire [51:0] half_ptr     = mem_rd_data[`DCL_PTR_MSB:`DCL_PTR_LSB];

  // Walk state machine
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state                 <= ST_IDLE;
      sid                   <= 16'h0000;
      has_pasid             <= 1'b0;
      page_req              <= 1'b0;
      ext_mode              <= 1'b0;
      word_cnt              <= 2'h0;
      ctx_w0                <= 64'h0000000000000000;
      ctx_w1                <= 64'h0000000000000000;
      ctx_base              <= 52'h0000000000000;
      req_ready             <= 1'b0;
      mem_rd_req            <= 1'b0;
      mem_rd_addr           <= 64'h0000000000000000;
      rsp_valid             <= 1'b0;
      rsp_fault             <= 1'b0;
      rsp_fault_code        <= `DCL_FLT_NONE;
      rsp_fault_report      <= 1'b0;
      rsp_trans_type        <= 3'h0;
      rsp_addr_width        <= 3'h0;
      rsp_sl_pointer        <= 52'h0000000000000;
      rsp_domain_id         <= 16'h0000;
      rsp_fault_disable     <= 1'b0;
      rsp_first_level       <= 1'b0;
      rsp_second_level      <= 1'b0;
      rsp_pasid_entry_addr  <= 64'h0000000000000000;
      rsp_page_request_pass <= 1'b0;
    end else begin
      mem_rd_req <= 1'b0;
      rsp_valid  <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready   <= 1'b0;
            sid         <= req_source_id;
            has_pasid   <= req_has_pasid;
            page_req    <= req_is_page_request;
            ext_mode    <= extended_context_supported && root_table_type_select;
            state       <= ST_ROOT;
            mem_rd_req  <= 1'b1;
            word_cnt    <= 2'h0;
            // Upper half of an extended root entry sits 8 bytes higher
            mem_rd_addr <= root_addr
                           + ((extended_context_supported && root_table_type_select
                              && upper_dev) ? 64'h0000000000000008
                                            : 64'h0000000000000000);
          end
        end
        ST_ROOT: begin
          if (mem_rd_valid) begin
            if (!half_present) begin
              // Lower, upper or regular root half absent
              rsp_valid        <= 1'b1;
              rsp_fault        <= 1'b1;
              rsp_fault_code   <= `DCL_FLT_ROOT;
              rsp_fault_report <= 1'b1;
              state            <= ST_DONE;
            end else begin
              ctx_base <= half_ptr;
              state    <= ST_CTX0;
            end
          end
        end
        ST_CTX0: begin
          mem_rd_req  <= 1'b1;
          mem_rd_addr <= ext_mode ? xctx_addr : ctx_addr;
          state       <= ST_CTX1;
        end
        ST_CTX1: begin
          if (mem_rd_valid) begin
            ctx_w0   <= mem_rd_data;
            word_cnt <= 2'h1;
            mem_rd_req  <= 1'b1;
            mem_rd_addr <= mem_rd_addr + 64'h0000000000000008;
            state    <= ST_CTX2;
          end
        end
        ST_CTX2: begin
          if (mem_rd_valid) begin
            ctx_w1 <= mem_rd_data;
            state  <= ST_DONE;
            rsp_valid <= 1'b1;
            // Fault and result decided below once both words are held
          end
        end
        ST_DONE: begin
          // Response published one cycle after the last word
          if (!rsp_fault && word_cnt == 2'h1) begin
            word_cnt              <= 2'h0;
            rsp_valid             <= 1'b1;
            rsp_fault             <= !ctx_w0[`DCL_PRESENT_BIT] || !type_ok;
            rsp_fault_code        <= !ctx_w0[`DCL_PRESENT_BIT] ? `DCL_FLT_CTX
                                     : (!type_ok ? `DCL_FLT_TYPE : `DCL_FLT_NONE);
            rsp_fault_disable     <= ctx_w0[`DCL_FPD_BIT];
            rsp_fault_report      <= (!ctx_w0[`DCL_PRESENT_BIT] || !type_ok)
                                     && !ctx_w0[`DCL_FPD_BIT];
            rsp_trans_type        <= tt;
            rsp_addr_width        <= ctx_w1[`DCL_AW_MSB:`DCL_AW_LSB];
            rsp_sl_pointer        <= ctx_w0[`DCL_PTR_MSB:`DCL_PTR_LSB];
            rsp_domain_id         <= ctx_w1[`DCL_DID_MSB:`DCL_DID_LSB];
            rsp_first_level       <= fl;
            rsp_second_level      <= sl;
            rsp_pasid_entry_addr  <= ext_mode ? pasid_addr : 64'h0000000000000000;
            rsp_page_request_pass <= ext_mode && page_req
                                     && ctx_w0[`DCL_PRE_BIT];
          end else begin
            rsp_valid <= 1'b0;
            rsp_fault <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/dcl_defines.vh ====
// Purpose: constants for the DMA device context lookup block
// Assumes: 64-bit memory read port, 128-bit root and regular context entry, 256-bit extended context entry
// Notes: entry bit positions are a simplified packing held in one place
// What this block does
// - Extended support plus root type select means base points to extended root table.
// - Extended root table is 4KB, 256 entries, one per bus.
// - Extended root entry splits into lower and upper 64-bit halves.
// - Device numbers 0-15 follow the lower table pointer.
// - Device numbers 16-31 follow the upper table pointer.
// - Lower half not present gives a translation fault.
// - Upper half not present gives a translation fault.
// - Lower and upper context tables hold 128 extended entries each.
// - Regular context table holds 256 entries, one per function.
// - Context entry is chosen by low 8 bits of source id.
// - Context entry not present blocks request with translation fault.
// - Regular context entries serve only requests without process identifier.
// - Translation type decides admitted requests and translation kind.
// - Domain address width comes from the context entry.
// - Second-level pointer comes from the context entry.
// - Domain identifier is output to tag cached translations.
// - Fault processing disable suppresses fault reporting.
// - Extended entries accept requests with and without process identifier.
// - Process requests get first level, others second unless pass-through; nesting gives both.
// - Per-process table pointer located through extended entry, 8-byte entries.
// - Page requests forwarded only when page request enable is set.
// - Root entry is chosen by bus number in upper 8 source id bits.
// - Regular root table is 4KB with 256 entries.
// - Regular root entry not present gives a translation fault.
`ifndef DCL_DEFINES_VH
`define DCL_DEFINES_VH
`define DCL_ROOT_ENTRY_SHIFT   4
`define DCL_CTX_ENTRY_SHIFT    4
`define DCL_XCTX_ENTRY_SHIFT   5
`define DCL_PASID_ENTRY_SHIFT  3
`define DCL_PRESENT_BIT        0
`define DCL_FPD_BIT            1
`define DCL_TT_LSB             2
`define DCL_TT_MSB             4
`define DCL_PRE_BIT            11
`define DCL_PTR_LSB            12
`define DCL_PTR_MSB            63
`define DCL_AW_LSB             0
`define DCL_AW_MSB             2
`define DCL_DID_LSB            8
`define DCL_DID_MSB            23
`define DCL_TT_UNTRANS         3'h0
`define DCL_TT_SL_ONLY         3'h1
`define DCL_TT_PASSTHRU        3'h2
`define DCL_TT_FL_ONLY         3'h4
`define DCL_TT_NESTED          3'h5
`define DCL_FLT_NONE           3'h0
`define DCL_FLT_ROOT           3'h1
`define DCL_FLT_CTX            3'h2
`define DCL_FLT_TYPE           3'h3
`define DCL_FLT_BUS            3'h4
`endif

// ==== rtl/dcl_fetch_addr.v ====
// Purpose: forms a table entry fetch address from a base and an index
// Assumes: base is 4KB aligned so adding the scaled index never carries past bit 11
// Notes: one instance per table level
`timescale 1ns/1ps
`include "dcl_defines.vh"
module dcl_fetch_addr #(
  parameter SHIFT = 4
) (
  input  wire [51:0] base_page,
  input  wire [7:0]  index,
  output wire [63:0] addr
);
  wire [11:0] offset;
  // Index times entry size within the 4KB page
  assign offset = {4'h0, index} << SHIFT;
  assign addr   = {base_page, offset};
endmodule

// ==== sim/dcl_lookup_checker.sv ====
// Purpose: concurrent checks of the lookup walk at the block's ports
// Assumes: entry layout and pulse timing as the hand-over gives them
// Notes: helper logic counts memory beats and keeps both context words
`timescale 1ns/1ps
module dcl_lookup_checker (
  input wire        ref_clk,
  input wire        reset,
  input wire        req_valid,
  input wire        req_ready,
  input wire        req_has_pasid,
  input wire [15:0] req_source_id,
  input wire        extended_context_supported,
  input wire        root_table_type_select,
  input wire [51:0] root_table_base_register,
  input wire        mem_rd_req,
  input wire [63:0] mem_rd_addr,
  input wire        mem_rd_valid,
  input wire [63:0] mem_rd_data,
  input wire        rsp_valid,
  input wire        rsp_fault,
  input wire [2:0]  rsp_fault_code,
  input wire        rsp_fault_report,
  input wire        rsp_first_level,
  input wire        rsp_second_level,
  input wire [2:0]  rsp_addr_width,
  input wire [51:0] rsp_sl_pointer,
  input wire [15:0] rsp_domain_id
);
  reg  [1:0]   beat;
  reg  [9:0]   req_q;
  reg  [127:0] w_q;
  wire         take = req_valid && req_ready;
  wire         ext = extended_context_supported && root_table_type_select;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Keeps the request and shifts in each returned word
  always @(posedge ref_clk or posedge reset) begin
    if (reset)
      beat <= 2'h0;
    else if (take) begin
      beat  <= 2'h0;
      req_q <= {ext, req_has_pasid, req_source_id[7:0]};
    end else if (mem_rd_valid) begin
      beat <= beat + 2'h1;
      w_q  <= {mem_rd_data, w_q[127:64]};
    end
  end
  property p_root_addr;
    take |=> mem_rd_req && mem_rd_addr == {$past(root_table_base_register), 12'h000}
      + {$past(req_source_id[15:8]), 4'h0} + {$past(ext && req_source_id[7]), 3'h0};
  endproperty
  a_root_addr: assert property (p_root_addr) else $error("root address");
  property p_root_fault;
    mem_rd_valid && beat == 2'h0 && !mem_rd_data[0] |=>
      rsp_valid && rsp_fault && rsp_fault_code == 3'h1 && rsp_fault_report;
  endproperty
  a_root_fault: assert property (p_root_fault) else $error("root fault");
  property p_ctx_addr;
    mem_rd_valid && beat == 2'h0 && mem_rd_data[0] && (req_q[9] || !req_q[8]) |-> ##2
      mem_rd_req && mem_rd_addr == {$past(mem_rd_data[63:12], 2), 12'h000}
      + (req_q[9] ? {req_q[6:0], 5'h00} : {req_q[7:0], 4'h0});
  endproperty
  a_ctx_addr: assert property (p_ctx_addr) else $error("context address");
  property p_word1;
    mem_rd_valid && beat == 2'h1 |=> mem_rd_req && mem_rd_addr == $past(mem_rd_addr) + 64'h8;
  endproperty
  a_word1: assert property (p_word1) else $error("second word address");
  property p_ctx_fault;
    rsp_valid && $past(rsp_valid) && !w_q[0] |-> rsp_fault && rsp_fault_code == 3'h2;
  endproperty
  a_ctx_fault: assert property (p_ctx_fault) else $error("context fault");
  property p_report;
    rsp_valid && $past(rsp_valid) && rsp_fault |-> rsp_fault_report == !w_q[1];
  endproperty
  a_report: assert property (p_report) else $error("fault report");
  property p_fields;
    rsp_valid && $past(rsp_valid) && !rsp_fault |-> rsp_sl_pointer == w_q[63:12]
      && rsp_addr_width == w_q[66:64] && rsp_domain_id == w_q[87:72];
  endproperty
  a_fields: assert property (p_fields) else $error("result fields");
  property p_levels;
    rsp_valid && $past(rsp_valid) && !rsp_fault && req_q[9] && req_q[8] |->
      rsp_first_level && rsp_second_level == (w_q[4:2] == 3'h5);
  endproperty
  a_levels: assert property (p_levels) else $error("levels");
  c_root_fault: cover property (rsp_valid && rsp_fault_code == 3'h1);
  c_ctx_fault: cover property (rsp_valid && rsp_fault_code == 3'h2);
  c_ext_pasid: cover property (rsp_valid && !rsp_fault && req_q[9] && req_q[8]);
endmodule
bind dcl_lookup dcl_lookup_checker dcl_lookup_checker_inst (.*);

// ==== sim/dcl_mem_model.sv ====
// Purpose: system memory answering table reads
// Assumes: one read outstanding; lat sets the answer delay
// Notes: data line inverts each idle cycle
`timescale 1ns/1ps
module dcl_mem_model (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        mem_rd_req,
  input  wire [63:0] mem_rd_addr,
  output reg         mem_rd_valid,
  output reg  [63:0] mem_rd_data
);
  logic [63:0] mem [logic [63:0]];
  logic [63:0] addr_q;
  int          lat = 1;
  int          cnt;
  // Returns the stored word lat cycles after each read
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 64'h0;
      cnt          <= 0;
    end else begin
      mem_rd_valid <= cnt == 1;
      mem_rd_data  <= (cnt == 1) ? (mem.exists(addr_q) ? mem[addr_q] : 64'h0) : ~mem_rd_data;
      cnt          <= mem_rd_req ? lat : (cnt > 0 ? cnt - 1 : 0);
      if (mem_rd_req)
        addr_q <= mem_rd_addr;
    end
  end
endmodule

// ==== sim/dcl_lookup_tb.sv ====
// Purpose: bench for the device context lookup
// Assumes: memory model holds the tables
// Notes: each test is one lookup then compares
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dcl_lookup_tb;
  localparam [63:0] RB = 64'h10000;
  reg         ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_has_pasid = 1'b0;
  reg         extended_context_supported = 1'b0, root_table_type_select = 1'b0;
  reg         req_is_page_request = 1'b0;
  reg  [51:0] root_table_base_register = RB[63:12];
  reg  [15:0] req_source_id = 16'h0;
  wire        req_ready, mem_rd_req, mem_rd_valid, rsp_valid, rsp_fault, rsp_fault_report;
  wire        rsp_fault_disable, rsp_first_level, rsp_second_level, rsp_page_request_pass;
  wire [2:0]  rsp_fault_code, rsp_trans_type, rsp_addr_width;
  wire [15:0] rsp_domain_id;
  wire [51:0] rsp_sl_pointer;
  wire [63:0] mem_rd_addr, mem_rd_data, rsp_pasid_entry_addr;
  int         err_count = 0, num_checks = 0;
  dcl_lookup dcl_lookup_inst (.*);
  dcl_mem_model dcl_mem_model_inst (.*);
  // Reference clock
  always #25 ref_clk = ~ref_clk;
  // Stores root word and context entry, then runs one lookup to its result
  task automatic go(input e, input [15:0] s, input p, q, input [63:0] rw, w0, w1);
    logic [63:0] ca;
    ca = {rw[63:12], 12'h000} + (e ? {s[6:0], 5'h00} : {s[7:0], 4'h0});
    dcl_mem_model_inst.mem[RB + {s[15:8], 4'h0} + {e & s[7], 3'h0}] = rw;
    dcl_mem_model_inst.mem[ca] = w0;
    dcl_mem_model_inst.mem[ca + 64'h8] = w1;
    @(posedge ref_clk);
    #1;
    {extended_context_supported, root_table_type_select, req_source_id} = {e, e, s};
    {req_has_pasid, req_is_page_request, req_valid} = {p, q, 1'b1};
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    // The fault flag stands only with its pulse; a root fault has a single pulse
    while (rsp_valid !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    // Otherwise the results come with the second pulse
    if (rsp_fault !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  // Compares a clean result with the entry words
  task automatic ok(input e, input [63:0] w0, w1, input f, l2);
    `CHK(rsp_fault, 1'b0);
    `CHK(rsp_trans_type, w0[4:2]);
    `CHK({rsp_addr_width, rsp_domain_id}, {w1[2:0], w1[23:8]});
    `CHK(rsp_sl_pointer, w0[63:12]);
    `CHK(rsp_fault_disable, w0[1]);
    `CHK(rsp_pasid_entry_addr, e ? {w1[63:12], 12'h000} : 64'h0);
    `CHK({rsp_first_level, rsp_second_level}, {f, l2});
  endtask
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    // Regular root table
    go(0, 16'h0312, 0, 0, 64'h20001, 64'hABCDE005, 64'h12345A03);
    ok(0, 64'hABCDE005, 64'h12345A03, 0, 1);
    go(0, 16'h0412, 0, 0, 64'h20000, 64'h0, 64'h0);
    `CHK({rsp_fault, rsp_fault_code, rsp_fault_report}, 5'h13);
    go(0, 16'h0312, 0, 0, 64'h20001, 64'hABCDE006, 64'h12345A03);
    `CHK({rsp_fault, rsp_fault_code, rsp_fault_report}, 5'h14);
    go(0, 16'h0312, 1, 0, 64'h20001, 64'hABCDE005, 64'h12345A03);
    `CHK(rsp_fault, 1'b1);
    // Extended root table, slow memory for the first two lookups
    dcl_mem_model_inst.lat = 3;
    go(1, 16'h052B, 1, 1, 64'h30001, 64'hABCDE811, 64'h55555102);
    ok(1, 64'hABCDE811, 64'h55555102, 1, 0);
    `CHK(rsp_page_request_pass, 1'b1);
    go(1, 16'h05C5, 1, 1, 64'h40001, 64'hABCDE015, 64'h55555102);
    ok(1, 64'hABCDE015, 64'h55555102, 1, 1);
    `CHK(rsp_page_request_pass, 1'b0);
    dcl_mem_model_inst.lat = 1;
    // Same domain and pointer as the first entry
    go(1, 16'h0510, 0, 0, 64'h30001, 64'hABCDE005, 64'h12345A03);
    ok(1, 64'hABCDE005, 64'h12345A03, 0, 1);
    go(1, 16'h0701, 0, 0, 64'h30000, 64'h0, 64'h0);
    `CHK({rsp_fault, rsp_fault_code}, 4'h9);
    dcl_mem_model_inst.mem[RB + 64'h70] = 64'h30001;
    go(1, 16'h0781, 0, 0, 64'h40000, 64'h0, 64'h0);
    `CHK({rsp_fault, rsp_fault_code}, 4'h9);
    finish_test;
  end
  // Watchdog
  initial begin
    #200000;
    err_count++;
    finish_test;
  end
endmodule
